// ### hw/msw_wave_table.sv
// Microstep wave table for one driver channel: table registers,
// position tracking and both coil current values.
// Assumes the microstep sequencer and register port share i_core_clk.
//
// Operation
// - Own programmable wave table per driver, reset to a quarter sine.
// - Stored quarter wave 0 to 90 degrees is mirrored to a full period.
// - The 10-bit position counter indexes the full extended period.
// - Quarter wave is 256 one-bit entries in eight 32-bit words.
// - Each step adds segment inclination, plus one when the entry bit is set.
// - Four segments, base inclination -1, 0, 1 or 2; slopes may descend.
// - Segments bounded by boundaries one to three, each ending one below next.
// - Each microstep computes both coil currents into readable registers.
// - Passing position zero reloads both coil currents absolutely.
// - First wave start field gives coil A value at position zero.
// - Second wave start field gives coil B value, the 90 degree entry.
// - Defaults: boundaries 128, 255, 255; segment 0 code 10, others 01.

`timescale 1ns/1ps

module msw_wave_table (
	input  wire logic                        i_core_clk,
	input  wire logic                        i_rst_b,
	input  wire logic [msw_pkg::POS_W-1:0]   i_microstep_position_counter,
	input  wire logic                        i_reg_wr_en,
	input  wire logic [msw_pkg::IDX_W-1:0]   i_reg_index,
	input  wire logic [31:0]                 i_reg_wdata,
	output logic [31:0]                      o_reg_rdata,
	output logic signed [msw_pkg::CUR_W-1:0] o_coil_a_current,
	output logic signed [msw_pkg::CUR_W-1:0] o_coil_b_current,
	output logic                             o_position_aligned
);
	import msw_pkg::*;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic                    rst_meta_b;
	logic                    rst_sync_b;
	logic [31:0]             wave_table_word [TABLE_WORDS];
	logic [31:0]             wave_segment_select;
	logic [7:0]              first_wave_start_value;
	logic [7:0]              second_wave_start_value;
	logic [255:0]            table_bits;
	logic [POS_W-1:0]        walk_position;
	logic [POS_W-1:0]        next_walk_position;
	logic [POS_W-1:0]        position_gap;
	logic                    walk_step;
	logic                    zero_reached;
	logic [POS_W-1:0]        coil_b_position;
	logic [POS_W-1:0]        next_coil_b_position;
	logic signed [2:0]       coil_a_delta;
	logic signed [2:0]       coil_b_delta;
	msw_track_t              track_state;
	msw_track_t              next_track_state;
	logic [31:0]             next_reg_rdata;

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------

	// Quarter wave entry for a full period position
	function automatic logic [7:0] table_index(
		input logic [POS_W-1:0] position
	);
		// Odd quarters run the stored wave backwards
		return position[8] ? ~position[7:0] : position[7:0];
	endfunction : table_index

	// Inclination of one stored entry, base by segment plus entry bit
	function automatic logic signed [2:0] entry_step(
		input logic [7:0]   entry,
		input logic [255:0] bits,
		input logic [31:0]  select
	);
		logic [1:0]        code;
		logic signed [2:0] base;
		logic [8:0]        dest;
		// Segment of the entry being stepped into, so that the default
		// quarter sine ends exactly on its second start value
		dest = {1'b0, entry} + 9'h001;
		code = select[SEL_INCL_LSB+6 +: 2];
		if (dest < {1'b0, select[SEL_BOUND1_LSB +: 8]}) begin
			code = select[SEL_INCL_LSB +: 2];
		end else if (dest < {1'b0, select[SEL_BOUND2_LSB +: 8]}) begin
			code = select[SEL_INCL_LSB+2 +: 2];
		end else if (dest < {1'b0, select[SEL_BOUND3_LSB +: 8]}) begin
			code = select[SEL_INCL_LSB+4 +: 2];
		end
		base = $signed({1'b0, code}) - 3'sd1;
		return base + $signed({2'b00, bits[entry]});
	endfunction : entry_step

	// Signed change of a coil magnitude between neighbouring positions
	function automatic logic signed [2:0] coil_delta(
		input logic [POS_W-1:0] from_position,
		input logic [POS_W-1:0] to_position,
		input logic [255:0]     bits,
		input logic [31:0]      select
	);
		logic [8:0] from_entry;
		logic [8:0] to_entry;
		from_entry = {1'b0, table_index(from_position)};
		to_entry   = {1'b0, table_index(to_position)};
		if (to_entry == from_entry + 9'h001) begin
			return entry_step(from_entry[7:0], bits, select);
		end else if (from_entry == to_entry + 9'h001) begin
			return -entry_step(to_entry[7:0], bits, select);
		end
		// Quarter boundary: the mirrored entry repeats
		return 3'sd0;
	endfunction : coil_delta

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------

	// Two-stage release of the asynchronous reset
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rst_meta_b <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_meta_b <= 1'b1;
			rst_sync_b <= rst_meta_b;
		end
	end

	// ----------------------------------------------------------------
	// Table and configuration registers
	// ----------------------------------------------------------------

	// Table words, preset to the quarter sine
	always_ff @(posedge i_core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			for (int w = 0; w < TABLE_WORDS; w++) begin
				wave_table_word[w] <= WAVE_TABLE_RESET[w];
			end
		end else if (i_reg_wr_en && i_reg_index <= IDX_TABLE_LAST) begin
			wave_table_word[i_reg_index[2:0]] <= i_reg_wdata;
		end
	end

	// Segment boundaries and inclination codes
	always_ff @(posedge i_core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			wave_segment_select <= SEGMENT_SELECT_RESET;
		end else if (i_reg_wr_en && i_reg_index == IDX_SEGMENT_SELECT) begin
			wave_segment_select <= i_reg_wdata;
		end
	end

	// Start values of both waves
	always_ff @(posedge i_core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			first_wave_start_value  <= FIRST_START_RESET;
			second_wave_start_value <= SECOND_START_RESET;
		end else if (i_reg_wr_en && i_reg_index == IDX_START_VALUES) begin
			first_wave_start_value  <= i_reg_wdata[START_FIRST_LSB +: 8];
			second_wave_start_value <= i_reg_wdata[START_SECOND_LSB +: 8];
		end
	end

	// Flat view of the 256 entry bits, word 0 lowest
	always_comb begin
		table_bits = '0;
		for (int w = 0; w < TABLE_WORDS; w++) begin
			table_bits[w*32 +: 32] = wave_table_word[w];
		end
	end

	// ----------------------------------------------------------------
	// Register read port
	// ----------------------------------------------------------------

	// Read data select; unmapped indices read zero
	always_comb begin
		next_reg_rdata = 32'h00000000;
		if (i_reg_index <= IDX_TABLE_LAST) begin
			next_reg_rdata = wave_table_word[i_reg_index[2:0]];
		end else begin
			case (i_reg_index)
				IDX_SEGMENT_SELECT: begin
					next_reg_rdata = wave_segment_select;
				end
				IDX_START_VALUES: begin
					next_reg_rdata[START_FIRST_LSB +: 8]  = first_wave_start_value;
					next_reg_rdata[START_SECOND_LSB +: 8] = second_wave_start_value;
				end
				IDX_COIL_CURRENTS: begin
					next_reg_rdata[CUR_W-1:0]            = o_coil_a_current;
					next_reg_rdata[COIL_B_LSB +: CUR_W]  = o_coil_b_current;
				end
				default: begin
					next_reg_rdata = 32'h00000000;
				end
			endcase
		end
	end

	// Registered read data, valid the cycle after the index
	always_ff @(posedge i_core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			o_reg_rdata <= 32'h00000000;
		end else begin
			o_reg_rdata <= next_reg_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Position walk
	// ----------------------------------------------------------------

	// One microstep per cycle toward the sequencer position, short way round
	always_comb begin
		position_gap       = i_microstep_position_counter - walk_position;
		walk_step          = (position_gap != '0);
		next_walk_position = walk_position;
		next_track_state   = TRACK_ALIGNED;
		if (walk_step) begin
			if (position_gap[POS_W-1]) begin
				next_walk_position = walk_position - 10'h001;
			end else begin
				next_walk_position = walk_position + 10'h001;
			end
		end
		case (track_state)
			TRACK_ALIGNED: begin
				next_track_state = walk_step ? TRACK_WALKING : TRACK_ALIGNED;
			end
			TRACK_WALKING: begin
				if (next_walk_position == i_microstep_position_counter) begin
					next_track_state = TRACK_ALIGNED;
				end else begin
					next_track_state = TRACK_WALKING;
				end
			end
			default: begin
				next_track_state = TRACK_ALIGNED;
			end
		endcase
	end

	// Arrival at zero forces the absolute start values
	assign zero_reached = walk_step && (next_walk_position == '0);

	// Positions of the second coil, a quarter period ahead
	assign coil_b_position      = walk_position + COIL_B_OFFSET;
	assign next_coil_b_position = next_walk_position + COIL_B_OFFSET;

	// Incremental change of each coil for this step
	assign coil_a_delta = coil_delta(walk_position, next_walk_position,
		table_bits, wave_segment_select);
	assign coil_b_delta = coil_delta(coil_b_position, next_coil_b_position,
		table_bits, wave_segment_select);

	// Walk pointer
	always_ff @(posedge i_core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			walk_position <= '0;
		end else begin
			walk_position <= next_walk_position;
		end
	end

	// Tracking state and aligned flag
	always_ff @(posedge i_core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			track_state        <= TRACK_ALIGNED;
			o_position_aligned <= 1'b1;
		end else begin
			track_state        <= next_track_state;
			o_position_aligned <= (next_track_state == TRACK_ALIGNED);
		end
	end

	// ----------------------------------------------------------------
	// Coil accumulators
	// ----------------------------------------------------------------

	// Coil A starts from the first wave start value at zero
	msw_coil_track #(
		.RESET_MAGNITUDE (FIRST_START_RESET)
	) u_coil_a (
		.i_core_clk     (i_core_clk),
		.i_rst_b        (rst_sync_b),
		.i_step         (walk_step),
		.i_reload       (zero_reached),
		.i_reload_value (first_wave_start_value),
		.i_delta        (coil_a_delta),
		.i_negative     (next_walk_position[9]),
		.o_current      (o_coil_a_current)
	);

	// Coil B starts from the 90 degree entry
	msw_coil_track #(
		.RESET_MAGNITUDE (SECOND_START_RESET)
	) u_coil_b (
		.i_core_clk     (i_core_clk),
		.i_rst_b        (rst_sync_b),
		.i_step         (walk_step),
		.i_reload       (zero_reached),
		.i_reload_value (second_wave_start_value),
		.i_delta        (coil_b_delta),
		.i_negative     (next_coil_b_position[9]),
		.o_current      (o_coil_b_current)
	);

endmodule : msw_wave_table

// ### hw/msw_pkg.sv
// Constants for the microstep wave table block: register indices,
// field positions, reset values and the tracking state encoding.
// Assumes a SystemVerilog package is compiled before every design file.

package msw_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int unsigned POS_W       = 10;
	localparam int unsigned CUR_W       = 9;
	localparam int unsigned IDX_W       = 4;
	localparam int unsigned TABLE_WORDS = 8;

	// ----------------------------------------------------------------
	// Register indices on the register port
	// ----------------------------------------------------------------
	localparam logic [3:0] IDX_TABLE_LAST     = 4'h7;
	localparam logic [3:0] IDX_SEGMENT_SELECT = 4'h8;
	localparam logic [3:0] IDX_START_VALUES   = 4'h9;
	localparam logic [3:0] IDX_COIL_CURRENTS  = 4'hA;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int unsigned SEL_INCL_LSB     = 0;
	localparam int unsigned SEL_BOUND1_LSB   = 8;
	localparam int unsigned SEL_BOUND2_LSB   = 16;
	localparam int unsigned SEL_BOUND3_LSB   = 24;
	localparam int unsigned START_FIRST_LSB  = 0;
	localparam int unsigned START_SECOND_LSB = 16;
	localparam int unsigned COIL_B_LSB       = 16;

	// ----------------------------------------------------------------
	// Reset values: quarter sine, default segments, start values
	// ----------------------------------------------------------------
	localparam logic [7:0][31:0] WAVE_TABLE_RESET = {
		32'h00404222, 32'h49295556, 32'hB5BB777D, 32'hFBFFFFFF,
		32'h10104222, 32'h24492929, 32'h4A9554AA, 32'hAAAAB554
	};
	localparam logic [31:0] SEGMENT_SELECT_RESET = 32'hFFFF8056;
	localparam logic [31:0] START_VALUES_RESET   = 32'h00F70000;
	localparam logic [7:0]  FIRST_START_RESET    = START_VALUES_RESET[7:0];
	localparam logic [7:0]  SECOND_START_RESET   = START_VALUES_RESET[23:16];

	// Position offset of the second coil (quarter period)
	localparam logic [9:0] COIL_B_OFFSET = 10'h100;

	// ----------------------------------------------------------------
	// Tracking state
	// ----------------------------------------------------------------
	typedef enum logic [0:0] {
		TRACK_ALIGNED = 1'b0,
		TRACK_WALKING = 1'b1
	} msw_track_t;

endpackage : msw_pkg

// ### hw/msw_coil_track.sv
// One coil current accumulator of the microstep wave table.
// Assumes a synchronous reset copy and step inputs from the same clock.

`timescale 1ns/1ps

module msw_coil_track #(
	parameter logic [7:0] RESET_MAGNITUDE = 8'h00
) (
	input  wire logic                      i_core_clk,
	input  wire logic                      i_rst_b,
	input  wire logic                      i_step,
	input  wire logic                      i_reload,
	input  wire logic [7:0]                i_reload_value,
	input  wire logic signed [2:0]         i_delta,
	input  wire logic                      i_negative,
	output logic signed [msw_pkg::CUR_W-1:0] o_current
);
	import msw_pkg::*;

	logic signed [CUR_W-1:0] magnitude;
	logic signed [CUR_W-1:0] next_magnitude;

	// ----------------------------------------------------------------
	// Quarter wave magnitude update
	// ----------------------------------------------------------------

	// Absolute reload at zero, else incremental add
	always_comb begin
		if (i_reload) begin
			next_magnitude = $signed({1'b0, i_reload_value});
		end else begin
			next_magnitude = magnitude + CUR_W'(i_delta);
		end
	end

	// Magnitude register, moves once per walked microstep
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			magnitude <= $signed({1'b0, RESET_MAGNITUDE});
		end else if (i_step) begin
			magnitude <= next_magnitude;
		end
	end

	// Readable coil current with the half-wave sign applied
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_current <= $signed({1'b0, RESET_MAGNITUDE});
		end else if (i_step) begin
			o_current <= i_negative ? -next_magnitude : next_magnitude;
		end
	end

endmodule : msw_coil_track

// ### bench/msw_wave_table_monitor.sv
// Checker for the microstep wave table, bound to the top module.
// Assumes it sees only the top module's ports on one clock.

`timescale 1ns/1ps

module msw_wave_table_monitor
	import msw_pkg::*;
(
	input wire logic                        i_core_clk,
	input wire logic                        i_rst_b,
	input wire logic [msw_pkg::POS_W-1:0]   i_microstep_position_counter,
	input wire logic                        i_reg_wr_en,
	input wire logic [msw_pkg::IDX_W-1:0]   i_reg_index,
	input wire logic [31:0]                 i_reg_wdata,
	input wire logic [31:0]                 o_reg_rdata,
	input wire logic signed [msw_pkg::CUR_W-1:0] o_coil_a_current,
	input wire logic signed [msw_pkg::CUR_W-1:0] o_coil_b_current,
	input wire logic                        o_position_aligned
);
	logic [31:0] start_shadow;
	logic [9:0]  stable_cnt;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);

	// Shadow of the start word, unused bits dropped
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			start_shadow <= START_VALUES_RESET;
		end else if (i_reg_wr_en && i_reg_index == IDX_START_VALUES) begin
			start_shadow <= i_reg_wdata & 32'h00FF00FF;
		end
	end

	// Cycles since the input position last moved
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			stable_cnt <= 10'h000;
		end else if ($changed(i_microstep_position_counter)) begin
			stable_cnt <= 10'h000;
		end else if (stable_cnt != 10'h3FF) begin
			stable_cnt <= stable_cnt + 10'h001;
		end
	end

	AST_RESET_VALUES: assert property (
		$rose(i_rst_b) |-> o_coil_a_current == 9'sd0 && o_coil_b_current == 9'sd247 && o_position_aligned)
		else $error("coil values after reset wrong");
	AST_RESERVED_READ: assert property (
		i_reg_index > IDX_COIL_CURRENTS |=> o_reg_rdata == 32'h00000000)
		else $error("unmapped index read not zero");
	AST_START_FIELDS: assert property (
		i_reg_index == IDX_START_VALUES |=> (o_reg_rdata & 32'hFF00FF00) == 32'h00000000)
		else $error("start word unused bits set");
	AST_CURRENT_READ: assert property (
		i_reg_index == IDX_COIL_CURRENTS |=>
		o_reg_rdata == {7'h00, $past(o_coil_b_current), 7'h00, $past(o_coil_a_current)})
		else $error("coil current word wrong");
	AST_WRITE_READBACK: assert property (
		(i_reg_wr_en && i_reg_index <= IDX_SEGMENT_SELECT) ##1 (!i_reg_wr_en && $stable(i_reg_index))
		|=> o_reg_rdata == $past(i_reg_wdata, 2))
		else $error("written word not read back");
	AST_HOLD_STILL: assert property (
		$stable(i_microstep_position_counter) [*3] ##0 o_position_aligned
		|=> $stable(o_coil_a_current) && $stable(o_coil_b_current))
		else $error("currents moved without a step");
	AST_ALIGN_WITHIN: assert property (
		stable_cnt == 10'd520 |-> o_position_aligned)
		else $error("walk did not reach the position");
	AST_ZERO_RELOAD: assert property (
		$rose(o_position_aligned) && i_microstep_position_counter == 10'h000 |->
		o_coil_a_current == {1'b0, start_shadow[7:0]} && o_coil_b_current == {1'b0, start_shadow[23:16]})
		else $error("no absolute reload at zero");

endmodule : msw_wave_table_monitor

bind msw_wave_table msw_wave_table_monitor i_monitor (.i_core_clk, .i_rst_b, .i_microstep_position_counter,
	.i_reg_wr_en, .i_reg_index, .i_reg_wdata, .o_reg_rdata, .o_coil_a_current, .o_coil_b_current,
	.o_position_aligned);

// ### bench/msw_wave_table_tb_top.sv
// Testbench for the microstep wave table: register access and walk checks.
// Assumes the package and design are compiled first; the checker is bound.

`timescale 1ns/1ps

module msw_wave_table_tb_top;
	import msw_pkg::*;

	logic                    core_clk  = 1'b0;
	logic                    rst_b     = 1'b0;
	logic [POS_W-1:0]        position  = '0;
	logic                    wr_en     = 1'b0;
	logic [IDX_W-1:0]        reg_index = '0;
	logic [31:0]             wdata     = '0;
	logic [31:0]             rdata;
	logic signed [CUR_W-1:0] coil_a;
	logic signed [CUR_W-1:0] coil_b;
	logic                    aligned;
	logic [255:0]            tbl = WAVE_TABLE_RESET;
	logic [31:0]             sel = 32'hFFFF8056;
	logic [31:0]             st  = 32'h00F70000;
	int                      mismatches = 0;
	int                      checks = 0;
	logic [9:0] walk_list [16] = '{1, 63, 64, 127, 128, 191, 192, 255, 256, 511, 512, 700, 0, 1000, 5, 0};

	// 250 MHz clock
	always #2 core_clk = ~core_clk;

	msw_wave_table i_dut (.i_core_clk(core_clk), .i_rst_b(rst_b), .i_microstep_position_counter(position),
		.i_reg_wr_en(wr_en), .i_reg_index(reg_index), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
		.o_coil_a_current(coil_a), .o_coil_b_current(coil_b), .o_position_aligned(aligned));

	// ----------------------------------------------------------------
	// Reference: quarter wave magnitude and mirrored full period
	// ----------------------------------------------------------------
	function automatic logic [8:0] mag(input logic [7:0] j);
		logic [8:0] v;
		logic [1:0] code;
		v = {1'b0, st[7:0]};
		for (int k = 0; k < j; k++) begin
			code = ((k + 1) < sel[15:8]) ? sel[1:0] : ((k + 1) < sel[23:16]) ? sel[3:2] :
				((k + 1) < sel[31:24]) ? sel[5:4] : sel[7:6];
			v = v + {7'h00, code} - 9'h001 + {8'h00, tbl[k]};
		end
		return v;
	endfunction : mag

	function automatic logic [8:0] expc(input logic [9:0] p);
		logic [8:0] m;
		m = mag(p[8] ? ~p[7:0] : p[7:0]);
		return p[9] ? 9'h000 - m : m;
	endfunction : expc

	// ----------------------------------------------------------------
	// Access tasks
	// ----------------------------------------------------------------
	task automatic complete_run();
		$display("mismatches %0d checks %0d", mismatches, checks);
		if (mismatches == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [3:0] i, input logic [31:0] d);
		@(negedge core_clk);
		wr_en = 1'b1;
		reg_index = i;
		wdata = d;
		@(negedge core_clk);
		wr_en = 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] i, input logic [31:0] exp);
		@(negedge core_clk);
		reg_index = i;
		@(negedge core_clk);
		chk("rdata", exp, rdata);
	endtask : rd

	task automatic go(input logic [9:0] p);
		int n;
		n = 0;
		@(negedge core_clk);
		position = p;
		repeat (2) @(negedge core_clk);
		while (aligned !== 1'b1 && n < 600) begin
			@(negedge core_clk);
			n++;
		end
		if (aligned !== 1'b1) begin
			mismatches++;
			$display("mismatch aligned expected 1 seen %b", aligned);
			complete_run();
		end
		chk("coil_a", {23'h0, expc(p)}, {23'h0, coil_a});
		chk("coil_b", {23'h0, expc(p + 10'h100)}, {23'h0, coil_b});
	endtask : go

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(negedge core_clk);
		rst_b = 1'b1;
		repeat (3) @(posedge core_clk);
		for (int i = 0; i < 8; i++) begin
			rd(i[3:0], WAVE_TABLE_RESET[i]);
		end
		rd(IDX_SEGMENT_SELECT, 32'hFFFF8056);
		rd(IDX_START_VALUES, 32'h00F70000);
		rd(IDX_COIL_CURRENTS, 32'h00F70000);
		rd(4'hB, 32'h00000000);
		rd(4'hF, 32'h00000000);
		for (int i = 0; i < 16; i++) begin
			go(walk_list[i]);
		end
		wr(IDX_COIL_CURRENTS, 32'hFFFFFFFF);
		rd(IDX_COIL_CURRENTS, {7'h00, expc(10'h100), 7'h00, expc(10'h000)});
		wr(IDX_START_VALUES, 32'hFFFFFFFF);
		rd(IDX_START_VALUES, 32'h00FF00FF);
		// Custom wave using all four inclination codes
		tbl = {8{32'h11111111}};
		sel = 32'hC080401E;
		st = 32'h00000002;
		st[23:16] = mag(8'hFF);
		for (int i = 0; i < 8; i++) begin
			wr(i[3:0], 32'h11111111);
		end
		wr(IDX_SEGMENT_SELECT, sel);
		wr(IDX_START_VALUES, st);
		rd(IDX_SEGMENT_SELECT, sel);
		rd(4'h3, 32'h11111111);
		@(negedge core_clk);
		position = 10'h001;
		repeat (3) @(negedge core_clk);
		go(10'h000);
		for (int i = 0; i < 16; i++) begin
			go(walk_list[i]);
		end
		repeat (530) @(negedge core_clk);
		rst_b = 1'b0;
		repeat (2) @(negedge core_clk);
		rst_b = 1'b1;
		repeat (3) @(posedge core_clk);
		rd(IDX_SEGMENT_SELECT, 32'hFFFF8056);
		complete_run();
	end

endmodule : msw_wave_table_tb_top
